//--- pwr_wdt_pkg.sv
package pwr_wdt_pkg;

    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] PCR_OFFSET        = 8'h00;
    localparam logic [7:0] WDT_CTRL_OFFSET   = 8'h04;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h08;
    localparam logic [7:0] IRQ_CLEAR_OFFSET  = 8'h0c;
    localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h10;
    localparam logic [7:0] WDT_COUNT_OFFSET  = 8'h14;

    // Power control register fields
    localparam int PCR_IDLE_ARM_BIT  = 0;
    localparam int PCR_PD_ARM_BIT    = 1;
    localparam int PCR_SLOW_BIT      = 4;
    localparam int PCR_IDLE_GO_BIT   = 5;
    localparam int PCR_PD_GO_BIT     = 6;
    localparam logic [7:0] PCR_RESET = 8'h00;
    // Bits kept when a sleep mode is left
    localparam logic [7:0] PCR_EXIT_MASK = 8'h9c;

    // Watchdog control register fields
    localparam int WDT_START_BIT   = 0;
    localparam int WDT_CLEAR_BIT   = 1;
    localparam int WDT_RUNNING_BIT = 0;
    localparam int WDT_FLAG_BIT    = 2;

    // Interrupt status bits
    localparam int IRQ_WDT_RESET_BIT = 0;
    localparam int IRQ_IDLE_EXIT_BIT = 1;
    localparam int IRQ_PD_EXIT_BIT   = 2;
    localparam int IRQ_BITS          = 3;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // Clock divider for slow down mode
    localparam int SLOW_DIV            = 8;
    localparam logic [2:0] DIV_RESET   = 3'h0;
    localparam logic [2:0] DIV_LAST    = 3'h7;

    // Watchdog timing
    localparam int WDT_TIMEOUT_US        = 65532;
    localparam int WDT_REF_OSC_MHZ       = 12;
    localparam logic [15:0] WDT_END_COUNT = 16'hfffc;
    localparam logic [15:0] WDT_COUNT_RESET = 16'h0000;
    localparam int WDT_TIMEOUT_CYCLES    = WDT_TIMEOUT_US * WDT_REF_OSC_MHZ;
    localparam int WDT_TICK_CYCLES       = WDT_TIMEOUT_CYCLES / 65532;
    localparam int OSC_PER_INSTR         = 12;
    localparam int WDT_RST_INSTR         = 4;
    localparam int WDT_RST_CYCLES        = WDT_RST_INSTR * OSC_PER_INSTR;

    typedef enum logic [1:0] {
        MODE_RUN   = 2'b00,
        MODE_IDLE  = 2'b01,
        MODE_PDOWN = 2'b11
    } power_mode_t;

endpackage : pwr_wdt_pkg

//--- power_mode_and_watchdog_supervisor.sv
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none

module power_mode_and_watchdog_supervisor #(
    parameter int          TICK_CYCLES = pwr_wdt_pkg::WDT_TICK_CYCLES,
    parameter logic [15:0] WDT_END     = pwr_wdt_pkg::WDT_END_COUNT,
    parameter int          RST_CYCLES  = pwr_wdt_pkg::WDT_RST_CYCLES
) (
    input  wire logic        CLK,                 // Oscillator clock
    input  wire logic        RESET_N,             // Synchronous hardware reset, active low
    input  wire logic        WB_CYC_I,            // Wishbone cycle
    input  wire logic        WB_STB_I,            // Wishbone strobe
    input  wire logic        WB_WE_I,             // Wishbone write enable
    input  wire logic [7:0]  WB_ADR_I,            // Wishbone byte address
    input  wire logic [3:0]  WB_SEL_I,            // Wishbone byte select
    input  wire logic [31:0] WB_DAT_I,            // Wishbone write data
    output logic      [31:0] WB_DAT_O,            // Wishbone read data
    output logic             WB_ACK_O,            // Wishbone acknowledge
    input  wire logic        IRQ_REQ,             // Enabled interrupt pending
    input  wire logic        EXT_INT_ZERO_PIN_N,  // External interrupt 0 pin, active low
    output logic             CPU_CLK_EN,          // CPU clock enable
    output logic             PERIPH_CLK_EN,       // Peripheral clock enable
    output logic             OSC_EN,              // Oscillator enable
    output logic             INTERNAL_RESET,      // Watchdog reset, active high
    output logic             IRQ                  // Supervisor interrupt
);

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr == off);
    endfunction : hit

    logic        bus_req;
    logic        bus_wr;
    logic        lane0;
    logic        wr_pcr;
    logic        wr_wdt;
    logic        wr_clr;
    logic        wr_ena;
    logic [7:0]  wdata;

    assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    assign lane0   = WB_SEL_I[0];
    assign bus_wr  = bus_req & WB_WE_I & lane0;
    assign wdata   = WB_DAT_I[7:0];
    assign wr_pcr  = bus_wr & hit(WB_ADR_I, pwr_wdt_pkg::PCR_OFFSET);
    assign wr_wdt  = bus_wr & hit(WB_ADR_I, pwr_wdt_pkg::WDT_CTRL_OFFSET);
    assign wr_clr  = bus_wr & hit(WB_ADR_I, pwr_wdt_pkg::IRQ_CLEAR_OFFSET);
    assign wr_ena  = bus_wr & hit(WB_ADR_I, pwr_wdt_pkg::IRQ_ENABLE_OFFSET);

    // Pin synchroniser
    logic ext_interrupt_zero_pin_s1_reg;
    logic ext_interrupt_zero_pin_s2_reg;

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            ext_interrupt_zero_pin_s1_reg <= 1'b1;
            ext_interrupt_zero_pin_s2_reg <= 1'b1;
        end else begin
            ext_interrupt_zero_pin_s1_reg <= EXT_INT_ZERO_PIN_N;
            ext_interrupt_zero_pin_s2_reg <= ext_interrupt_zero_pin_s1_reg;
        end
    end

    // Watchdog state
    logic        wdt_running_reg;
    logic        wdt_running_next;
    logic        wdt_flag_reg;
    logic        wdt_flag_next;
    logic [15:0] wdt_count_reg;
    logic [15:0] wdt_count_next;
    logic [15:0] tick_cnt_reg;
    logic [15:0] tick_cnt_next;
    logic [7:0]  rst_cnt_reg;
    logic [7:0]  rst_cnt_next;
    logic        int_rst_reg;
    logic        int_rst_next;
    logic        wdt_fire;
    logic        in_wdt_rst;
    logic        periph_tick;

    assign in_wdt_rst = (rst_cnt_reg != 8'h00);

    always_comb begin
        wdt_running_next = wdt_running_reg;
        wdt_flag_next    = wdt_flag_reg;
        wdt_count_next   = wdt_count_reg;
        tick_cnt_next    = tick_cnt_reg;
        rst_cnt_next     = rst_cnt_reg;
        wdt_fire         = 1'b0;
        if (wr_wdt && wdata[pwr_wdt_pkg::WDT_START_BIT]) begin
            wdt_running_next = 1'b1;
        end
        if (in_wdt_rst) begin
            rst_cnt_next   = rst_cnt_reg - 8'h01;
            wdt_count_next = pwr_wdt_pkg::WDT_COUNT_RESET;
            tick_cnt_next  = 16'h0000;
        end else if (wr_wdt && wdata[pwr_wdt_pkg::WDT_CLEAR_BIT]) begin
            wdt_count_next = pwr_wdt_pkg::WDT_COUNT_RESET;
            tick_cnt_next  = 16'h0000;
        end else if (wdt_running_reg && wdt_count_reg == WDT_END) begin
            wdt_fire       = 1'b1;
            rst_cnt_next   = 8'(RST_CYCLES);
            wdt_count_next = pwr_wdt_pkg::WDT_COUNT_RESET;
            tick_cnt_next  = 16'h0000;
            wdt_flag_next  = 1'b1;
        end else if (wdt_running_reg && periph_tick) begin
            if (tick_cnt_reg == 16'(TICK_CYCLES - 1)) begin
                tick_cnt_next  = 16'h0000;
                wdt_count_next = wdt_count_reg + 16'h0001;
            end else begin
                tick_cnt_next  = tick_cnt_reg + 16'h0001;
            end
        end
        int_rst_next = (rst_cnt_next != 8'h00);
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            wdt_running_reg <= 1'b0;
            wdt_flag_reg    <= 1'b0;
            wdt_count_reg   <= pwr_wdt_pkg::WDT_COUNT_RESET;
            tick_cnt_reg    <= 16'h0000;
            rst_cnt_reg     <= 8'h00;
            int_rst_reg     <= 1'b0;
        end else begin
            wdt_running_reg <= wdt_running_next;
            wdt_flag_reg    <= wdt_flag_next;
            wdt_count_reg   <= wdt_count_next;
            tick_cnt_reg    <= tick_cnt_next;
            rst_cnt_reg     <= rst_cnt_next;
            int_rst_reg     <= int_rst_next;
        end
    end

    // Power mode state
    pwr_wdt_pkg::power_mode_t mode_reg;
    pwr_wdt_pkg::power_mode_t mode_next;
    logic [7:0]  pcr_reg;
    logic [7:0]  pcr_next;
    logic        arm_idle_reg;
    logic        arm_idle_next;
    logic        arm_pd_reg;
    logic        arm_pd_next;
    logic        idle_exit;
    logic        pd_exit;

    always_comb begin
        mode_next     = mode_reg;
        pcr_next      = pcr_reg;
        arm_idle_next = arm_idle_reg;
        arm_pd_next   = arm_pd_reg;
        idle_exit     = 1'b0;
        pd_exit       = 1'b0;
        if (bus_wr) begin
            arm_idle_next = 1'b0;
            arm_pd_next   = 1'b0;
        end
        if (wdt_fire || in_wdt_rst) begin
            mode_next     = pwr_wdt_pkg::MODE_RUN;
            pcr_next      = pwr_wdt_pkg::PCR_RESET;
            arm_idle_next = 1'b0;
            arm_pd_next   = 1'b0;
        end else begin
            case (mode_reg)
                pwr_wdt_pkg::MODE_RUN: begin
                    if (wr_pcr) begin
                        pcr_next = wdata;
                        pcr_next[pwr_wdt_pkg::PCR_IDLE_GO_BIT] = 1'b0;
                        pcr_next[pwr_wdt_pkg::PCR_PD_GO_BIT]   = 1'b0;
                        if (arm_pd_reg && wdata[pwr_wdt_pkg::PCR_PD_GO_BIT]) begin
                            mode_next = pwr_wdt_pkg::MODE_PDOWN;
                            pcr_next[pwr_wdt_pkg::PCR_PD_GO_BIT] = 1'b1;
                        end else if (arm_idle_reg && wdata[pwr_wdt_pkg::PCR_IDLE_GO_BIT]) begin
                            mode_next = pwr_wdt_pkg::MODE_IDLE;
                            pcr_next[pwr_wdt_pkg::PCR_IDLE_GO_BIT] = 1'b1;
                        end else begin
                            arm_idle_next = wdata[pwr_wdt_pkg::PCR_IDLE_ARM_BIT]
                                          & ~wdata[pwr_wdt_pkg::PCR_IDLE_GO_BIT];
                            arm_pd_next   = wdata[pwr_wdt_pkg::PCR_PD_ARM_BIT]
                                          & ~wdata[pwr_wdt_pkg::PCR_PD_GO_BIT];
                        end
                    end
                end
                pwr_wdt_pkg::MODE_IDLE: begin
                    if (IRQ_REQ) begin
                        mode_next = pwr_wdt_pkg::MODE_RUN;
                        pcr_next  = pcr_reg & pwr_wdt_pkg::PCR_EXIT_MASK;
                        idle_exit = 1'b1;
                    end
                end
                pwr_wdt_pkg::MODE_PDOWN: begin
                    if (!ext_interrupt_zero_pin_s2_reg) begin
                        mode_next = pwr_wdt_pkg::MODE_RUN;
                        pcr_next  = pcr_reg & pwr_wdt_pkg::PCR_EXIT_MASK;
                        pd_exit   = 1'b1;
                    end
                end
                default: begin
                    mode_next = pwr_wdt_pkg::MODE_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            mode_reg     <= pwr_wdt_pkg::MODE_RUN;
            pcr_reg      <= pwr_wdt_pkg::PCR_RESET;
            arm_idle_reg <= 1'b0;
            arm_pd_reg   <= 1'b0;
        end else begin
            mode_reg     <= mode_next;
            pcr_reg      <= pcr_next;
            arm_idle_reg <= arm_idle_next;
            arm_pd_reg   <= arm_pd_next;
        end
    end

    // Clock enables
    logic [2:0] div_reg;
    logic [2:0] div_next;
    logic       slow;
    logic       cpu_en_next;
    logic       periph_en_next;
    logic       osc_en_next;
    logic       cpu_en_reg;
    logic       periph_en_reg;
    logic       osc_en_reg;

    assign slow        = pcr_reg[pwr_wdt_pkg::PCR_SLOW_BIT];
    assign periph_tick = periph_en_reg;

    always_comb begin
        div_next       = div_reg + 3'h1;
        periph_en_next = slow ? (div_reg == pwr_wdt_pkg::DIV_LAST) : 1'b1;
        osc_en_next    = 1'b1;
        if (mode_next == pwr_wdt_pkg::MODE_PDOWN) begin
            periph_en_next = 1'b0;
            osc_en_next    = 1'b0;
            div_next       = pwr_wdt_pkg::DIV_RESET;
        end
        cpu_en_next = periph_en_next & (mode_next == pwr_wdt_pkg::MODE_RUN);
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            div_reg       <= pwr_wdt_pkg::DIV_RESET;
            cpu_en_reg    <= 1'b1;
            periph_en_reg <= 1'b1;
            osc_en_reg    <= 1'b1;
        end else begin
            div_reg       <= div_next;
            cpu_en_reg    <= cpu_en_next;
            periph_en_reg <= periph_en_next;
            osc_en_reg    <= osc_en_next;
        end
    end

    // Interrupt registers and bus answer
    logic [2:0]  irq_status_reg;
    logic [2:0]  irq_status_next;
    logic [2:0]  irq_enable_reg;
    logic [2:0]  irq_enable_next;
    logic [2:0]  events;
    logic        irq_next;
    logic        irq_reg;
    logic        ack_next;
    logic        ack_reg;
    logic [31:0] rdata_next;
    logic [31:0] rdata_reg;

    always_comb begin
        events = 3'h0;
        events[pwr_wdt_pkg::IRQ_WDT_RESET_BIT] = wdt_fire;
        events[pwr_wdt_pkg::IRQ_IDLE_EXIT_BIT] = idle_exit;
        events[pwr_wdt_pkg::IRQ_PD_EXIT_BIT]   = pd_exit;
        irq_status_next = irq_status_reg;
        if (wr_clr) begin
            irq_status_next = irq_status_reg & ~wdata[2:0];
        end
        irq_status_next = irq_status_next | events;
        irq_enable_next = wr_ena ? wdata[2:0] : irq_enable_reg;
        irq_next        = |(irq_status_next & irq_enable_next);
        ack_next        = bus_req;
        rdata_next      = 32'h0000_0000;
        if (bus_req && !WB_WE_I) begin
            case (WB_ADR_I)
                pwr_wdt_pkg::PCR_OFFSET: begin
                    rdata_next[7:0] = pcr_reg;
                end
                pwr_wdt_pkg::WDT_CTRL_OFFSET: begin
                    rdata_next[pwr_wdt_pkg::WDT_RUNNING_BIT] = wdt_running_reg;
                    rdata_next[pwr_wdt_pkg::WDT_FLAG_BIT]    = wdt_flag_reg;
                end
                pwr_wdt_pkg::IRQ_STATUS_OFFSET: begin
                    rdata_next[2:0] = irq_status_reg;
                end
                pwr_wdt_pkg::IRQ_ENABLE_OFFSET: begin
                    rdata_next[2:0] = irq_enable_reg;
                end
                pwr_wdt_pkg::WDT_COUNT_OFFSET: begin
                    rdata_next[15:0] = wdt_count_reg;
                end
                default: begin
                    rdata_next = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            irq_status_reg <= pwr_wdt_pkg::IRQ_RESET;
            irq_enable_reg <= pwr_wdt_pkg::IRQ_RESET;
            irq_reg        <= 1'b0;
            ack_reg        <= 1'b0;
            rdata_reg      <= 32'h0000_0000;
        end else begin
            irq_status_reg <= irq_status_next;
            irq_enable_reg <= irq_enable_next;
            irq_reg        <= irq_next;
            ack_reg        <= ack_next;
            rdata_reg      <= rdata_next;
        end
    end

    assign WB_ACK_O       = ack_reg;
    assign WB_DAT_O       = rdata_reg;
    assign IRQ            = irq_reg;
    assign CPU_CLK_EN     = cpu_en_reg;
    assign PERIPH_CLK_EN  = periph_en_reg;
    assign OSC_EN         = osc_en_reg;
    assign INTERNAL_RESET = int_rst_reg;

endmodule : power_mode_and_watchdog_supervisor

`default_nettype wire

//--- supervisor_assertions.sv
`timescale 1ns/1ns
`default_nettype none

module supervisor_assertions #(
    parameter int RST_CYCLES = 48
) (
    input wire logic CLK,                 // Clock
    input wire logic RESET_N,             // Reset, active low
    input wire logic WB_CYC_I,            // Bus cycle
    input wire logic WB_STB_I,            // Bus strobe
    input wire logic WB_ACK_O,            // Bus acknowledge
    input wire logic IRQ_REQ,             // Interrupt pending
    input wire logic EXT_INT_ZERO_PIN_N,  // Wake pin
    input wire logic CPU_CLK_EN,          // CPU clock enable
    input wire logic PERIPH_CLK_EN,       // Peripheral clock enable
    input wire logic OSC_EN,              // Oscillator enable
    input wire logic INTERNAL_RESET       // Watchdog reset
);
    logic [7:0] rst_len_reg;
    logic [7:0] rst_len_next;

    // Length of the current watchdog reset pulse
    always_comb begin
        rst_len_next = INTERNAL_RESET ? rst_len_reg + 8'h01 : 8'h00;
    end
    always_ff @(posedge CLK) begin
        rst_len_reg <= RESET_N ? rst_len_next : 8'h00;
    end

    default clocking dc @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);

    sequence s_request;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence s_slow_gap;
        PERIPH_CLK_EN ##1 (!PERIPH_CLK_EN && OSC_EN && !WB_CYC_I && !INTERNAL_RESET) [*7];
    endsequence

    property p_ack_next;
        s_request |=> WB_ACK_O;
    endproperty
    property p_ack_pulse;
        WB_ACK_O |=> !WB_ACK_O;
    endproperty
    property p_cpu_needs_periph;
        CPU_CLK_EN |-> PERIPH_CLK_EN && OSC_EN;
    endproperty
    property p_pd_all_off;
        !OSC_EN |-> !CPU_CLK_EN && !PERIPH_CLK_EN;
    endproperty
    property p_idle_exit;
        PERIPH_CLK_EN && !CPU_CLK_EN && IRQ_REQ |-> ##[1:10] CPU_CLK_EN;
    endproperty
    property p_pd_hold;
        (EXT_INT_ZERO_PIN_N [*3] ##0 !OSC_EN) |=> !OSC_EN;
    endproperty
    property p_pd_exit;
        (!OSC_EN && !EXT_INT_ZERO_PIN_N) [*3] |=> OSC_EN;
    endproperty
    property p_slow_period;
        s_slow_gap |=> PERIPH_CLK_EN;
    endproperty
    property p_rst_len;
        $fell(INTERNAL_RESET) |-> rst_len_reg == 8'(RST_CYCLES);
    endproperty

    a_ack_next:         assert property (p_ack_next) else $error("ack missing after request");
    a_ack_pulse:        assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_cpu_needs_periph: assert property (p_cpu_needs_periph) else $error("cpu clocked alone");
    a_pd_all_off:       assert property (p_pd_all_off) else $error("clock enabled in power down");
    a_idle_exit:        assert property (p_idle_exit) else $error("idle not left on interrupt");
    a_pd_hold:          assert property (p_pd_hold) else $error("power down left without wake");
    a_pd_exit:          assert property (p_pd_exit) else $error("power down not left on pin");
    a_slow_period:      assert property (p_slow_period) else $error("slow pulse period wrong");
    a_rst_len:          assert property (p_rst_len) else $error("watchdog reset length wrong");
endmodule : supervisor_assertions

bind power_mode_and_watchdog_supervisor supervisor_assertions #(.RST_CYCLES(RST_CYCLES)) u_chk (
    .CLK(CLK), .RESET_N(RESET_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
    .IRQ_REQ(IRQ_REQ), .EXT_INT_ZERO_PIN_N(EXT_INT_ZERO_PIN_N), .CPU_CLK_EN(CPU_CLK_EN),
    .PERIPH_CLK_EN(PERIPH_CLK_EN), .OSC_EN(OSC_EN), .INTERNAL_RESET(INTERNAL_RESET));

`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    logic        clk;
    logic        rst_n;
    logic        cyc;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat_w;
    logic [31:0] dat_r;
    logic        ack;
    logic        irq_req;
    logic        pin_n;
    logic        cpu_en;
    logic        per_en;
    logic        osc_en;
    logic        int_rst;
    logic        irq;
    logic [31:0] q;
    logic [31:0] ens;
    int          miscompares;
    int          samples_checked;
    int          n_cpu;
    int          n_per;
    int          n;

    assign ens = {29'h0, cpu_en, per_en, osc_en};

    power_mode_and_watchdog_supervisor #(.TICK_CYCLES(1), .WDT_END(16'h0010), .RST_CYCLES(4)) DUT (
        .CLK(clk), .RESET_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack), .IRQ_REQ(irq_req),
        .EXT_INT_ZERO_PIN_N(pin_n), .CPU_CLK_EN(cpu_en), .PERIPH_CLK_EN(per_en), .OSC_EN(osc_en),
        .INTERNAL_RESET(int_rst), .IRQ(irq));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (ack !== 1'b1 && i < 20);
        if (ack !== 1'b1) begin
            miscompares++;
            $display("MISMATCH ack expected 1 seen 0");
            tally_and_finish();
        end else begin
            q = dat_r;
            cyc <= 1'b0;
            we <= 1'b0;
        end
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(name, exp, q);
    endtask : rd_chk

    task automatic count(input int cycles);
        n_cpu = 0;
        n_per = 0;
        repeat (cycles) begin
            @(negedge clk);
            n_cpu += int'(cpu_en === 1'b1);
            n_per += int'(per_en === 1'b1);
        end
    endtask : count

    task automatic pulse_irq();
        @(posedge clk);
        irq_req <= 1'b1;
        @(posedge clk);
        irq_req <= 1'b0;
        repeat (12) @(negedge clk);
    endtask : pulse_irq

    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        $display("MISMATCH run length expected end seen hang");
        tally_and_finish();
    end

    initial begin
        rst_n = 1'b0;
        cyc = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h1;
        dat_w = 32'h0;
        irq_req = 1'b0;
        pin_n = 1'b1;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check("enables", 32'h7, ens);
        rd_chk("pcr", pwr_wdt_pkg::PCR_OFFSET, 32'h0);
        rd_chk("status", pwr_wdt_pkg::IRQ_STATUS_OFFSET, 32'h0);
        rd_chk("wdt_ctrl", pwr_wdt_pkg::WDT_CTRL_OFFSET, 32'h0);
        rd_chk("unmapped", 8'h20, 32'h0);
        sel <= 4'h0;
        wr(pwr_wdt_pkg::PCR_OFFSET, 32'h0c);
        sel <= 4'h1;
        rd_chk("pcr_nosel", pwr_wdt_pkg::PCR_OFFSET, 32'h0);
        $display("test reset done");
        wr(pwr_wdt_pkg::IRQ_ENABLE_OFFSET, 32'h7);
        wr(pwr_wdt_pkg::PCR_OFFSET, 32'h01);
        wr(pwr_wdt_pkg::PCR_OFFSET, 32'h21);
        repeat (3) @(negedge clk);
        check("idle_enables", 32'h3, ens);
        rd_chk("pcr_idle", pwr_wdt_pkg::PCR_OFFSET, 32'h21);
        pulse_irq();
        check("idle_exit", 32'h7, ens);
        rd_chk("pcr_exit", pwr_wdt_pkg::PCR_OFFSET, 32'h0);
        rd_chk("status_idle", pwr_wdt_pkg::IRQ_STATUS_OFFSET, 32'h2);
        check("irq_set", 32'h1, {31'h0, irq});
        wr(pwr_wdt_pkg::IRQ_CLEAR_OFFSET, 32'h2);
        repeat (2) @(negedge clk);
        check("irq_clear", 32'h0, {31'h0, irq});
        wr(pwr_wdt_pkg::PCR_OFFSET, 32'h01);
        wr(pwr_wdt_pkg::IRQ_ENABLE_OFFSET, 32'h3);
        wr(pwr_wdt_pkg::PCR_OFFSET, 32'h21);
        repeat (3) @(negedge clk);
        check("disarmed", 32'h7, ens);
        $display("test idle done");
        wr(pwr_wdt_pkg::PCR_OFFSET, 32'h03);
        wr(pwr_wdt_pkg::PCR_OFFSET, 32'h43);
        repeat (3) @(negedge clk);
        check("pd_enables", 32'h0, ens);
        rd_chk("pcr_pd", pwr_wdt_pkg::PCR_OFFSET, 32'h43);
        repeat (10) @(negedge clk);
        check("pd_stays", 32'h0, ens);
        @(posedge clk);
        pin_n <= 1'b0;
        repeat (5) @(posedge clk);
        pin_n <= 1'b1;
        repeat (3) @(negedge clk);
        check("pd_exit", 32'h7, ens);
        rd_chk("status_pd", pwr_wdt_pkg::IRQ_STATUS_OFFSET, 32'h4);
        check("irq_masked", 32'h0, {31'h0, irq});
        wr(pwr_wdt_pkg::IRQ_ENABLE_OFFSET, 32'h7);
        repeat (2) @(negedge clk);
        check("irq_unmasked", 32'h1, {31'h0, irq});
        wr(pwr_wdt_pkg::IRQ_CLEAR_OFFSET, 32'h4);
        $display("test power down done");
        wr(pwr_wdt_pkg::PCR_OFFSET, 32'h10);
        count(64);
        check("slow_cpu", 32'd8, n_cpu);
        check("slow_per", 32'd8, n_per);
        wr(pwr_wdt_pkg::PCR_OFFSET, 32'h10 & 32'hef);
        count(64);
        check("fast_cpu", 32'd64, n_cpu);
        wr(pwr_wdt_pkg::PCR_OFFSET, 32'h01);
        wr(pwr_wdt_pkg::PCR_OFFSET, 32'h31);
        count(64);
        check("idle_slow_cpu", 32'd0, n_cpu);
        check("idle_slow_per", 32'd8, n_per);
        pulse_irq();
        rd_chk("pcr_slow_kept", pwr_wdt_pkg::PCR_OFFSET, 32'h10);
        count(64);
        check("slow_after", 32'd8, n_cpu);
        wr(pwr_wdt_pkg::PCR_OFFSET, 32'h0c);
        wr(pwr_wdt_pkg::IRQ_CLEAR_OFFSET, 32'h7);
        $display("test slow done");
        wr(pwr_wdt_pkg::PCR_OFFSET, 32'h12);
        wr(pwr_wdt_pkg::PCR_OFFSET, 32'h52);
        repeat (3) @(negedge clk);
        check("pd_slow_enables", 32'h0, ens);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check("reset_wake", 32'h7, ens);
        rd_chk("pcr_after_reset", pwr_wdt_pkg::PCR_OFFSET, 32'h0);
        $display("test reset wake done");
        repeat (30) @(negedge clk);
        rd_chk("count_stopped", pwr_wdt_pkg::WDT_COUNT_OFFSET, 32'h0);
        wr(pwr_wdt_pkg::WDT_CTRL_OFFSET, 32'h1);
        rd_chk("wdt_running", pwr_wdt_pkg::WDT_CTRL_OFFSET, 32'h1);
        repeat (8) @(negedge clk);
        wr(pwr_wdt_pkg::WDT_CTRL_OFFSET, 32'h2);
        n = 0;
        while (int_rst !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        check("timeout_window", 32'h1, {31'h0, n >= 14 && n <= 20});
        n = 0;
        while (int_rst === 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        check("reset_len", 32'd4, n);
        rd_chk("wdt_flag", pwr_wdt_pkg::WDT_CTRL_OFFSET, 32'h5);
        rd_chk("pcr_wdt_reset", pwr_wdt_pkg::PCR_OFFSET, 32'h0);
        rd_chk("status_wdt", pwr_wdt_pkg::IRQ_STATUS_OFFSET, 32'h1);
        wr(pwr_wdt_pkg::WDT_CTRL_OFFSET, 32'h0);
        bus(1'b0, pwr_wdt_pkg::WDT_CTRL_OFFSET, 32'h0);
        check("wdt_unstoppable", 32'h1, q & 32'h1);
        $display("test watchdog done");
        tally_and_finish();
    end
endmodule : tb_top

`default_nettype wire
